// ===== rtl/rse_strobe_exec.sv
/*
  Radio strobe executor: decodes command bytes from the serial link, runs the
  oscillator, purge, reply and receive-gate commands, keeps sticky faults with
  a masked interrupt, and offers its registers over AHB-Lite.
  Assumes rf_idle and frame_rx_active come from radio logic on hclk.
*/
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
// Contract
// - Oscillator shutdown turns the oscillator off; status byte returns during opcode. Here the oscillator stays on when rf_idle is low.
// - Oscillator shutdown while radio busy raises the misuse fault.
// - Oscillator shutdown or receive purge during reception raises reception cut.
// - Receive purge empties queue, resets demodulator; transmit purge empties, no fault.
// - Reply confirm sends an acknowledgement after frame, pending bit clear.
// - Reply confirm pending sends acknowledgement after frame, pending bit set.
// - Reply suppress blocks acknowledgement of current frame, overriding auto reply.
// - Any reply strobe without a frame in reception is misuse, nothing sent.
// - Gate bit raise sets mask bit 13 only.
// - Gate bit drop clears mask bit 13 only.
// - Gate bit drop leaving the gate all zero raises gate empty.
// - Gate merge ORs a 16-bit operand into the receive gate mask.
// - Gate intersect ANDs operand into mask; all-zero result raises gate empty.
module rse_strobe_exec (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial command link pins
  input wire logic sclk_pin,
  input wire logic csn_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // Radio state
  input wire logic rf_idle,
  input wire logic frame_rx_active,
  // Radio control
  output logic osc_enable,
  output logic rx_purge,
  output logic demod_reset,
  output logic tx_purge,
  output logic ack_send,
  output logic ack_pending_bit,
  output logic ack_suppress,
  output logic auto_reply_en,
  output logic [rse_pkg::GATE_W-1:0] gate_mask,
  // Interrupt
  output logic irq
);
  import rse_pkg::*;

  // ==========================================================================
  // Serial byte engine
  logic frame_start;
  logic frame_end;
  logic byte_valid;
  logic [7:0] byte_data;
  rse_status_type status_byte;

  rse_spi_byte u_spi (
    .hclk(hclk),
    .hresetn(hresetn),
    .sclk_pin(sclk_pin),
    .csn_pin(csn_pin),
    .mosi_pin(mosi_pin),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .reply_byte(status_byte),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  // ==========================================================================
  // Command sequencer
  rse_state_type state_q;
  rse_state_type state_d;
  logic [7:0] opcode_q;
  logic [7:0] arg_hi_q;
  rse_fault_type flt_q;
  rse_fault_type flt_set;
  logic [GATE_W-1:0] gate_d;
  logic gate_load;
  logic do_osc_off;
  logic do_rx_purge;
  logic do_tx_purge;
  logic do_confirm;
  logic do_confirm_pend;
  logic do_suppress;
  logic [GATE_W-1:0] operand;
  logic [2:0] irq_mask_q;

  assign operand = {arg_hi_q, byte_data};

  // Status byte loaded at select, shifted out under the opcode
  always_comb begin
    status_byte = '0;
    status_byte.osc_on = osc_enable;
    status_byte.frame_rx = frame_rx_active;
    status_byte.rf_idle = rf_idle;
    status_byte.misuse = flt_q.misuse;
    status_byte.cut = flt_q.cut;
    status_byte.gate_empty = flt_q.gate_empty;
    status_byte.ack_armed = ack_send;
  end

  // Decode and execute; a strobe acts as soon as its opcode byte is in
  always_comb begin
    state_d = state_q;
    flt_set = '0;
    gate_d = gate_mask;
    gate_load = 1'b0;
    do_osc_off = 1'b0;
    do_rx_purge = 1'b0;
    do_tx_purge = 1'b0;
    do_confirm = 1'b0;
    do_confirm_pend = 1'b0;
    do_suppress = 1'b0;
    case (state_q)
      ST_OPCODE: begin
        if (byte_valid) begin
          state_d = ST_DISCARD;
          case (byte_data)
            OP_OSC_SHUTDOWN: begin
              // Busy radio: report misuse and leave the oscillator running
              if (!rf_idle) begin
                flt_set.misuse = 1'b1;
              end else begin
                do_osc_off = 1'b1;
              end
              flt_set.cut = frame_rx_active;
            end
            OP_RX_PURGE: begin
              do_rx_purge = 1'b1;
              flt_set.cut = frame_rx_active;
            end
            OP_TX_PURGE: begin
              do_tx_purge = 1'b1;
            end
            OP_REPLY_CONFIRM, OP_REPLY_CONFIRM_PEND, OP_REPLY_SUPPRESS: begin
              if (!frame_rx_active) begin
                flt_set.misuse = 1'b1;
              end else begin
                do_confirm = (byte_data == OP_REPLY_CONFIRM);
                do_confirm_pend = (byte_data == OP_REPLY_CONFIRM_PEND);
                do_suppress = (byte_data == OP_REPLY_SUPPRESS);
              end
            end
            OP_GATE_BIT_RAISE: begin
              gate_d[GATE_BIT] = 1'b1;
              gate_load = 1'b1;
            end
            OP_GATE_BIT_DROP: begin
              gate_d[GATE_BIT] = 1'b0;
              gate_load = 1'b1;
              flt_set.gate_empty = (gate_d == '0);
            end
            OP_GATE_MERGE, OP_GATE_INTERSECT: begin
              state_d = ST_ARG_HI;
            end
            default: begin
              state_d = ST_DISCARD;
            end
          endcase
        end
      end
      ST_ARG_HI: begin
        if (byte_valid) begin
          state_d = ST_ARG_LO;
        end
      end
      ST_ARG_LO: begin
        // Operand complete only with both bytes in one select
        if (byte_valid) begin
          state_d = ST_DISCARD;
          gate_load = 1'b1;
          if (opcode_q == OP_GATE_MERGE) begin
            gate_d = gate_mask | operand;
          end else begin
            gate_d = gate_mask & operand;
            flt_set.gate_empty = (gate_d == '0);
          end
        end
      end
      ST_DISCARD: begin
        state_d = ST_DISCARD;
      end
      default: begin
        state_d = ST_OPCODE;
      end
    endcase
    // A new select always starts from the opcode; a cut operand is dropped
    if (frame_start || frame_end) begin
      state_d = ST_OPCODE;
    end
  end

  // Sequencer state and captured bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_OPCODE;
      opcode_q <= 8'h00;
      arg_hi_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (byte_valid && state_q == ST_OPCODE) begin
        opcode_q <= byte_data;
      end
      if (byte_valid && state_q == ST_ARG_HI) begin
        arg_hi_q <= byte_data;
      end
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait, always OKAY, data registered at address phase
  logic bus_access;
  logic bus_rd;
  logic mapped;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic irq_rd_clr;
  logic osc_start;
  logic [31:0] rd_mux;

  assign bus_access = hsel & htrans[1] & hready;
  assign mapped = (haddr[31:8] == 24'h000000);
  assign bus_rd = bus_access & ~hwrite & mapped;
  assign irq_rd_clr = bus_rd & (haddr[7:0] == ADDR_IRQ_STAT);
  assign osc_start = wr_pend_q & (wr_addr_q == ADDR_CTRL) & hwdata[CTRL_OSC_START];

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_CTRL: rd_mux[CTRL_AUTO_REPLY] = auto_reply_en;
      ADDR_STATE: rd_mux = {16'h0000, 8'h00, status_byte};
      ADDR_IRQ_STAT: rd_mux[FLT_W-1:0] = flt_q;
      ADDR_IRQ_MASK: rd_mux[FLT_W-1:0] = irq_mask_q;
      ADDR_GATE: rd_mux[GATE_W-1:0] = gate_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= bus_access & hwrite & mapped;
      if (bus_access) begin
        wr_addr_q <= haddr[7:0];
      end
      if (bus_rd) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Control register and interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_reply_en <= CTRL_AUTO_REPLY_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == ADDR_CTRL) begin
        auto_reply_en <= hwdata[CTRL_AUTO_REPLY];
      end
      if (wr_addr_q == ADDR_IRQ_MASK) begin
        irq_mask_q <= hwdata[FLT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Radio control outputs
  // Oscillator: shut by strobe, restarted by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable <= OSC_ON_RST;
    end else if (do_osc_off) begin
      osc_enable <= 1'b0;
    end else if (osc_start) begin
      osc_enable <= 1'b1;
    end
  end

  // Purge pulses, one hclk each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_purge <= 1'b0;
      demod_reset <= 1'b0;
      tx_purge <= 1'b0;
    end else begin
      rx_purge <= do_rx_purge;
      demod_reset <= do_rx_purge;
      tx_purge <= do_tx_purge;
    end
  end

  // Reply requests held until the frame ends; the last strobe wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_send <= 1'b0;
      ack_pending_bit <= 1'b0;
      ack_suppress <= 1'b0;
    end else if (do_confirm || do_confirm_pend) begin
      ack_send <= 1'b1;
      ack_pending_bit <= do_confirm_pend;
      ack_suppress <= 1'b0;
    end else if (do_suppress) begin
      ack_send <= 1'b0;
      ack_pending_bit <= 1'b0;
      ack_suppress <= 1'b1;
    end else if (!frame_rx_active) begin
      ack_send <= 1'b0;
      ack_pending_bit <= 1'b0;
      ack_suppress <= 1'b0;
    end
  end

  // Receive gate mask: commands take priority over a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_mask <= GATE_RST;
    end else if (gate_load) begin
      gate_mask <= gate_d;
    end else if (wr_pend_q && wr_addr_q == ADDR_GATE) begin
      gate_mask <= hwdata[GATE_W-1:0];
    end
  end

  // ==========================================================================
  // Sticky faults: a read clears, but a fault in that same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_q <= '0;
    end else begin
      flt_q <= (irq_rd_clr ? rse_fault_type'(3'h0) : flt_q) | flt_set;
    end
  end

  // Level interrupt from unmasked sticky faults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flt_q & irq_mask_q);
    end
  end

endmodule

// ===== rtl/rse_pkg.sv
/*
  Shared constants and types for the radio strobe executor: opcodes, register
  offsets, field positions, reset values, the fault vector and the status byte.
  Assumes a 32-bit AHB-Lite register bus and a byte-wide serial command link.
*/
package rse_pkg;

  // ==========================================================================
  // Command opcodes (values are a local choice)
  localparam logic [7:0] OP_OSC_SHUTDOWN = 8'h1e;
  localparam logic [7:0] OP_RX_PURGE = 8'h1f;
  localparam logic [7:0] OP_TX_PURGE = 8'h20;
  localparam logic [7:0] OP_REPLY_CONFIRM = 8'h21;
  localparam logic [7:0] OP_REPLY_CONFIRM_PEND = 8'h22;
  localparam logic [7:0] OP_REPLY_SUPPRESS = 8'h23;
  localparam logic [7:0] OP_GATE_BIT_RAISE = 8'h24;
  localparam logic [7:0] OP_GATE_BIT_DROP = 8'h25;
  localparam logic [7:0] OP_GATE_MERGE = 8'h26;
  localparam logic [7:0] OP_GATE_INTERSECT = 8'h27;

  // ==========================================================================
  // Receive gate mask
  localparam int unsigned GATE_W = 16;
  localparam int unsigned GATE_BIT = 13;
  localparam logic [15:0] GATE_RST = 16'h0000;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_GATE = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_AUTO_REPLY = 0;
  localparam int unsigned CTRL_OSC_START = 1;
  localparam logic CTRL_AUTO_REPLY_RST = 1'b0;
  localparam logic OSC_ON_RST = 1'b1;

  // Fault / interrupt bit positions
  localparam int unsigned FLT_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic gate_empty;   // bit 2
    logic cut;          // bit 1
    logic misuse;       // bit 0
  } rse_fault_type;

  typedef struct packed {
    logic osc_on;
    logic frame_rx;
    logic rf_idle;
    logic misuse;
    logic cut;
    logic gate_empty;
    logic ack_armed;
    logic spare;
  } rse_status_type;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_ARG_HI = 4'b0010,
    ST_ARG_LO = 4'b0100,
    ST_DISCARD = 4'b1000
  } rse_state_type;

endpackage

// ===== rtl/rse_spi_byte.sv
/*
  Serial byte engine for the command link: synchronises the pins to hclk,
  assembles MSB-first bytes and shifts a reply byte out.
  Assumes mode 0 framing: data sampled on sclk rise, changed on sclk fall,
  and sclk at least four hclk periods per phase.
*/
module rse_spi_byte (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins
  input wire logic sclk_pin,
  input wire logic csn_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // Byte side
  input wire logic [7:0] reply_byte,
  output logic frame_start,
  output logic frame_end,
  output logic byte_valid,
  output logic [7:0] byte_data
);

  // ==========================================================================
  // Two-stage synchronisers, third stage for edge detection
  logic [2:0] sclk_s_q;
  logic [2:0] csn_s_q;
  logic [1:0] mosi_s_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;

  // Stage one feeds stage two only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s_q <= 3'h0;
      csn_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
      csn_s_q <= {csn_s_q[1:0], csn_pin};
      mosi_s_q <= {mosi_s_q[0], mosi_pin};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & ~csn_s_q[1];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & ~csn_s_q[1];
  assign cs_fall = ~csn_s_q[1] & csn_s_q[2];
  assign cs_rise = csn_s_q[1] & ~csn_s_q[2];

  // Receive shift and byte strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (cs_fall) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        rx_sh_q <= {rx_sh_q[6:0], mosi_s_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          byte_valid <= 1'b1;
          byte_data <= {rx_sh_q[6:0], mosi_s_q[1]};
        end
      end
    end
  end

  // Reply shift: loaded at select, later bytes shift out zeros
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_q <= 8'h00;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      frame_start <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_start <= cs_fall;
      frame_end <= cs_rise;
      if (cs_fall) begin
        tx_sh_q <= {reply_byte[6:0], 1'b0};
        miso_o <= reply_byte[7];
        miso_oe <= 1'b1;
      end else if (cs_rise) begin
        miso_oe <= 1'b0;
      end else if (sclk_fall) begin
        miso_o <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

endmodule

// ===== test/rse_strobe_exec_assertions.sv
/*
  Checker for the radio strobe executor: timing relations between the serial
  select, the radio state inputs and the radio control outputs.
  Assumes it is bound to rse_strobe_exec and sees only that module's ports.
*/
module rse_strobe_exec_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial link
  input wire logic csn_pin,
  input wire logic miso_oe,
  // Radio state and control
  input wire logic rf_idle,
  input wire logic frame_rx_active,
  input wire logic osc_enable,
  input wire logic rx_purge,
  input wire logic demod_reset,
  input wire logic tx_purge,
  input wire logic ack_send,
  input wire logic ack_pending_bit,
  input wire logic ack_suppress
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  demod_pair_a: assert property (rx_purge |-> demod_reset && $stable(tx_purge))
    else $error("demodulator reset not paired with receive purge");
  rx_pulse_a: assert property (rx_purge |=> !rx_purge)
    else $error("receive purge longer than one cycle");
  tx_pulse_a: assert property ($rose(tx_purge) |=> !tx_purge && !rx_purge)
    else $error("transmit purge longer than one cycle");
  osc_idle_a: assert property ($fell(osc_enable) |-> $past(rf_idle))
    else $error("oscillator stopped while radio busy");
  ack_frame_a: assert property ($rose(ack_send) |-> $past(frame_rx_active))
    else $error("acknowledge armed without a frame");
  ack_excl_a: assert property (!(ack_send && ack_suppress))
    else $error("acknowledge armed while suppressed");
  pend_ack_a: assert property (ack_pending_bit |-> ack_send)
    else $error("pending bit without acknowledge");
  ack_clear_a: assert property ($fell(frame_rx_active) |-> ##[0:2] !ack_send)
    else $error("acknowledge kept after frame end");
  miso_drive_a: assert property ($fell(csn_pin) |-> ##[1:6] miso_oe)
    else $error("status byte not driven after select");
  miso_idle_a: assert property (csn_pin [*6] |-> !miso_oe)
    else $error("serial output driven while deselected");
endmodule

bind rse_strobe_exec rse_strobe_exec_chk rse_strobe_exec_chk_i (.hclk(hclk),
  .hresetn(hresetn), .csn_pin(csn_pin), .miso_oe(miso_oe), .rf_idle(rf_idle),
  .frame_rx_active(frame_rx_active), .osc_enable(osc_enable), .rx_purge(rx_purge),
  .demod_reset(demod_reset), .tx_purge(tx_purge), .ack_send(ack_send),
  .ack_pending_bit(ack_pending_bit), .ack_suppress(ack_suppress));

// ===== test/rse_host_model.sv
/*
  Host controller model: serial master in mode 0, MSB first, one command per
  select, capturing the status byte returned during the opcode.
  Assumes it is clocked by hclk and each phase lasts at least four cycles.
*/
module rse_host_model (
  // Clock
  input wire logic hclk,
  // Serial pins
  output logic sclk_pin,
  output logic csn_pin,
  output logic mosi_pin,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] status_q;

  // ==========================================================================
  // Idle levels; data line toggles while deselected so stale bits show
  initial begin
    sclk_pin = 1'b0;
    csn_pin = 1'b1;
    mosi_pin = 1'b0;
    status_q = 8'h00;
  end
  always @(posedge hclk) if (csn_pin) mosi_pin <= ~mosi_pin;

  // One frame: n bytes from the top of tx, h cycles per clock phase
  task automatic xfer(input int n, input logic [23:0] tx, input int h);
    int i;
    @(posedge hclk); csn_pin <= 1'b0;
    @(posedge hclk);
    for (i = 0; i < 8 * n; i++) begin
      mosi_pin <= tx[23-i];
      repeat (h) @(posedge hclk);
      if (i < 8) status_q <= {status_q[6:0], miso_oe ? miso_o : 1'bx};
      sclk_pin <= 1'b1;
      repeat (h) @(posedge hclk);
      sclk_pin <= 1'b0;
    end
    repeat (h) @(posedge hclk);
    csn_pin <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// ===== test/rse_strobe_exec_test.sv
/*
  Self-checking bench for the radio strobe executor: AHB-Lite register access,
  serial commands through the host model, read results checked from a queue.
  Assumes the design answers with zero wait states and settles within a frame.
*/
module rse_strobe_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rse_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rf_idle, frame_rx_active, irq;
  logic [31:0] haddr, hwdata, hrdata, r, d;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_m;
  logic sclk_pin, csn_pin, mosi_pin, miso_o, miso_oe, osc_enable, rx_purge, demod_reset;
  logic tx_purge, ack_send, ack_pending_bit, ack_suppress, auto_reply_en, rd_ph;
  logic [GATE_W-1:0] gate_mask;
  logic [31:0] exp_q[$];
  int errors, n_checks, cyc, n_rx, n_dm, n_tx, k;

  rse_strobe_exec rse_strobe_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sclk_pin(sclk_pin), .csn_pin(csn_pin), .mosi_pin(mosi_pin), .miso_o(miso_o),
    .miso_oe(miso_oe), .rf_idle(rf_idle), .frame_rx_active(frame_rx_active),
    .osc_enable(osc_enable), .rx_purge(rx_purge), .demod_reset(demod_reset),
    .tx_purge(tx_purge), .ack_send(ack_send), .ack_pending_bit(ack_pending_bit),
    .ack_suppress(ack_suppress), .auto_reply_en(auto_reply_en), .gate_mask(gate_mask),
    .irq(irq));
  rse_host_model rse_host_model_i (.hclk(hclk), .sclk_pin(sclk_pin), .csn_pin(csn_pin),
    .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe(miso_oe));

  // ==========================================================================
  // Clock, verdict and comparison
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read results, pulse counts and hang guard; data phase follows a taken read
  always @(posedge hclk) begin
    // Every read answer must also carry an OKAY response
    if (rd_ph && hreadyout === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (rx_purge === 1'b1) n_rx++;
    if (demod_reset === 1'b1) n_dm++;
    if (tx_purge === 1'b1) n_tx++;
    cyc++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Bus and command tasks
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  // Run one frame, then expect the irq level and the faults it left behind
  task automatic cmd(input logic [7:0] op, input int n, input logic [15:0] od,
                     input logic [2:0] flt);
    rse_host_model_i.xfer(n, {op, od}, 4 + $urandom % 3);
    chk({31'h0, irq}, {31'h0, |(flt & irq_m)});
    rd(ADDR_IRQ_STAT, {29'h0, flt});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; rf_idle = 1'b1; frame_rx_active = 1'b0;
    r = $urandom(32'h9629);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATE, 32'ha0);
    rd(ADDR_GATE, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(8'h14, 32'h0);
    ahb(1'b1, ADDR_IRQ_MASK, 32'h7);
    irq_m = 3'h7;
    rd(ADDR_IRQ_MASK, 32'h7);
    cmd(OP_OSC_SHUTDOWN, 1, 16'h0, 3'h0);
    chk({24'h0, rse_host_model_i.status_q}, 32'ha0);
    chk({31'h0, osc_enable}, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h2);
    rf_idle <= 1'b0;
    frame_rx_active <= 1'b1;
    cmd(OP_OSC_SHUTDOWN, 1, 16'h0, 3'h3);
    chk({31'h0, osc_enable}, 32'h1);
    cmd(OP_RX_PURGE, 1, 16'h0, 3'h2);
    cmd(OP_TX_PURGE, 1, 16'h0, 3'h0);
    frame_rx_active <= 1'b0;
    cmd(OP_RX_PURGE, 1, 16'h0, 3'h0);
    chk(n_rx, 2);
    chk(n_dm, 2);
    chk(n_tx, 1);
    ahb(1'b1, ADDR_CTRL, 32'h1);
    // The write lands on the edge the task returns at; look one edge later
    @(posedge hclk);
    chk({31'h0, auto_reply_en}, 32'h1);
    for (k = 0; k < 3; k++) begin
      frame_rx_active <= 1'b0;
      cmd(OP_REPLY_CONFIRM + k[7:0], 1, 16'h0, 3'h1);
      chk({ack_send, ack_pending_bit, ack_suppress}, 32'h0);
      frame_rx_active <= 1'b1;
      cmd(OP_REPLY_CONFIRM + k[7:0], 1, 16'h0, 3'h0);
      chk({ack_send, ack_pending_bit, ack_suppress}, 32'h164 >> (4 * k) & 32'h7);
    end
    frame_rx_active <= 1'b0;
    r = ($urandom & 32'hdfff) | 32'h1;
    ahb(1'b1, ADDR_GATE, r);
    cmd(OP_GATE_BIT_RAISE, 1, 16'h0, 3'h0);
    rd(ADDR_GATE, r | 32'h2000);
    cmd(OP_GATE_BIT_DROP, 1, 16'h0, 3'h0);
    rd(ADDR_GATE, r);
    ahb(1'b1, ADDR_GATE, 32'h0);
    cmd(OP_GATE_BIT_RAISE, 3, {OP_GATE_MERGE, 8'hff}, 3'h0);
    rd(ADDR_GATE, 32'h2000);
    cmd(OP_GATE_MERGE, 2, 16'hff00, 3'h0);
    rd(ADDR_GATE, 32'h2000);
    cmd(8'h55, 2, {OP_GATE_BIT_DROP, 8'h00}, 3'h0);
    rd(ADDR_GATE, 32'h2000);
    cmd(OP_GATE_BIT_DROP, 1, 16'h0, 3'h4);
    rd(ADDR_IRQ_STAT, 32'h0);
    r = $urandom & 32'hffff;
    d = $urandom & 32'hffff;
    ahb(1'b1, ADDR_GATE, r);
    cmd(OP_GATE_MERGE, 3, d[15:0], 3'h0);
    rd(ADDR_GATE, r | d);
    r = r | d;
    d = $urandom & 32'hffff;
    cmd(OP_GATE_INTERSECT, 3, d[15:0], ((r & d) == 0) ? 3'h4 : 3'h0);
    rd(ADDR_GATE, r & d);
    ahb(1'b1, ADDR_IRQ_MASK, 32'h1);
    irq_m = 3'h1;
    cmd(OP_GATE_INTERSECT, 3, 16'h0, 3'h4);
    rd(ADDR_GATE, 32'h0);
    stop_test();
  end
endmodule
